// *** rtl/amr_defines.vh ***
`ifndef AMR_DEFINES_VH
`define AMR_DEFINES_VH

// Register byte offsets
`define AMR_OFF_CTRL 8'h00
`define AMR_OFF_RELAY_SEL 8'h04
`define AMR_OFF_WDOG_TMO 8'h08
`define AMR_OFF_LOG_CFG 8'h0C
`define AMR_OFF_COND 8'h10
`define AMR_OFF_INT_STAT 8'h14
`define AMR_OFF_INT_CLR 8'h18
`define AMR_OFF_INT_EN 8'h1C

// Control register fields
`define AMR_CTRL_WDOG_EN 0
`define AMR_CTRL_LOG_SW 1
`define AMR_CTRL_LOG_MENU 2
`define AMR_CTRL_LOG_DIN 3
`define AMR_CTRL_REDUCE 4

// Reset values
`define AMR_RST_CTRL 5'h00
`define AMR_RST_RELAY_SEL 12'hFFF
`define AMR_RST_WDOG_TMO 16'h03E8
`define AMR_RST_LOG_CH 4'hA
`define AMR_RST_LOG_INT 8'h01

// Alarm vector bit positions
`define AMR_A_AUX_HIGH 0
`define AMR_A_LINE_LOSS 1
`define AMR_A_AUX_LOW 2
`define AMR_A_BAKEOUT 3
`define AMR_A_HEATER 4
`define AMR_A_ILIMIT 5
`define AMR_A_PHASE 6
`define AMR_A_CARD 7
`define AMR_A_SHORT 8
`define AMR_A_OVERTEMP 9
`define AMR_A_UNBAL 10
`define AMR_A_WDOG 11
`define AMR_NUM_ALARMS 12

// Logging limits
`define AMR_LOG_MAX_CH 4'hA
`define AMR_LOG_MIN_S 8'h01

// Timing
`define AMR_CLK_PERIOD_NS 5
`define AMR_MS_NS 1000000
`define AMR_S_MS 1000
`define AMR_BLINK_HALF_MS 500

`endif

// *** rtl/amr_alarm_monitor_relay.v ***
`timescale 1ns/10ps
`include "amr_defines.vh"
// Operation
// - Lamp lit while any alarm other than bakeout persists
// - Selected alarm other than bakeout de-energizes relay
// - Relay energized only on aux power, no tripping alarm
// - Configurable alarm combination drives relay
// - Flash matching message while condition persists
// - Watchdog timeout raises error, load power off
// - Overtemperature trips relay, holds load off
// - Current limit flagged; reduce on some variants
// - Line loss while electronics otherwise powered
// - Stuck switch with continuous output alarms
// - Unbalanced load alarm names offending leg
// - Heater break on high load resistance
// - Card fitted but access fails: error
// - Log up to ten parameters, one second minimum
// - Logging enabled by host, menu or input
module amr_alarm_monitor_relay #(
    parameter MS_CYCLES = `AMR_MS_NS / `AMR_CLK_PERIOD_NS
) (
    input wire CLK_IN, // System clock, 200 MHz
    input wire RESET_N_IN, // Synchronous reset, active low
    input wire PSEL_IN, // APB select
    input wire PENABLE_IN, // APB enable
    input wire PWRITE_IN, // APB direction
    input wire [7:0] PADDR_IN, // APB byte address
    input wire [31:0] PWDATA_IN, // APB write data
    output wire [31:0] PRDATA_OUT, // APB read data
    output wire PREADY_OUT, // APB ready
    output wire PSLVERR_OUT, // APB error, unmapped address
    input wire AUX_HIGH_IN, // Aux voltage above maximum
    input wire AUX_LOW_IN, // Aux voltage below minimum
    input wire LINE_PRESENT_IN, // Line power present
    input wire ELEC_POWERED_IN, // Electronics powered by any source
    input wire AUX_POWERED_IN, // Electronics fed by aux input
    input wire BAKEOUT_ACTIVE_IN, // Bakeout function running
    input wire LOAD_RES_HIGH_IN, // Load resistance above expected
    input wire CURRENT_OVER_IN, // Current above limit
    input wire PHASE_LOSS_IN, // One or more phases missing
    input wire CARD_PRESENT_IN, // Memory card fitted
    input wire CARD_FAIL_IN, // Card read or write failed
    input wire SWITCH_STUCK_IN, // Power switch stuck conducting
    input wire OUTPUT_CONT_ON_IN, // Output on continuously
    input wire OVERTEMP_IN, // Switch temperature sensor hot
    input wire [2:0] LEG_OUT_TOL_IN, // Per-leg balance out of tolerance
    input wire COMM_RX_IN, // Serial/USB receive activity line
    input wire LOG_DIN_IN, // Digital input for logging
    output wire ALARM_LAMP_OUT, // Front-panel alarm lamp
    output wire RELAY_ENERGIZE_OUT, // Alarm relay coil drive
    output wire [11:0] DISPLAY_MSG_OUT, // Active message set
    output wire DISPLAY_ALT_OUT, // Upper display shows messages
    output wire DISPLAY_FLASH_OUT, // Flash phase, high means visible
    output wire LOAD_POWER_OFF_OUT, // Force load power off
    output wire OUTPUT_REDUCE_OUT, // Reduce output for current limit
    output wire [2:0] UNBAL_LEG_OUT, // Legs out of tolerance
    output wire LOG_ACTIVE_OUT, // Logging running
    output wire LOG_SAMPLE_OUT, // One-cycle log sample strobe
    output wire [3:0] LOG_CHANNELS_OUT, // Parameters per sample
    output wire IRQ_OUT // Interrupt, level
);

    localparam NSYNC = 19;
    localparam [31:0] MS_MAX = MS_CYCLES - 1;

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers
    wire [NSYNC-1:0] raw_in;
    reg [NSYNC-1:0] s1_ff;
    reg [NSYNC-1:0] s2_ff;
    assign raw_in = {LOG_DIN_IN, COMM_RX_IN, LEG_OUT_TOL_IN, OVERTEMP_IN,
                     OUTPUT_CONT_ON_IN, SWITCH_STUCK_IN, CARD_FAIL_IN,
                     CARD_PRESENT_IN, PHASE_LOSS_IN, CURRENT_OVER_IN,
                     LOAD_RES_HIGH_IN, BAKEOUT_ACTIVE_IN, AUX_POWERED_IN,
                     ELEC_POWERED_IN, LINE_PRESENT_IN, AUX_LOW_IN, AUX_HIGH_IN};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always @(posedge CLK_IN) begin
                if (!RESET_N_IN) begin
                    s1_ff[gi] <= 1'b0;
                    s2_ff[gi] <= 1'b0;
                end else begin
                    s1_ff[gi] <= raw_in[gi];
                    s2_ff[gi] <= s1_ff[gi];
                end
            end
        end
    endgenerate

    wire aux_high = s2_ff[0];
    wire line_present = s2_ff[2];
    wire aux_low = s2_ff[1];
    wire elec_powered = s2_ff[3];
    wire aux_powered = s2_ff[4];
    wire bakeout = s2_ff[5];
    wire res_high = s2_ff[6];
    wire curr_over = s2_ff[7];
    wire phase_loss = s2_ff[8];
    wire card_present = s2_ff[9];
    wire card_fail = s2_ff[10];
    wire sw_stuck = s2_ff[11];
    wire out_cont_on = s2_ff[12];
    wire overtemp = s2_ff[13];
    wire [2:0] legs = s2_ff[16:14];
    wire comm_rx = s2_ff[17];
    wire log_din = s2_ff[18];

    ////////////////////////////////////////////////////////////////////
    // Configuration registers
    reg [4:0] ctrl_ff;
    reg [11:0] relay_sel_ff;
    reg [15:0] wdog_tmo_ff;
    reg [3:0] log_ch_ff;
    reg [7:0] log_int_ff;
    reg [11:0] int_stat_ff;
    reg [11:0] int_en_ff;
    reg [31:0] prdata_ff;
    reg pready_ff;
    reg pslverr_ff;

    ////////////////////////////////////////////////////////////////////
    // Millisecond tick and flash divider
    reg [31:0] ms_cnt_ff;
    reg ms_tick_ff;
    reg [9:0] blink_cnt_ff;
    reg flash_ff;

    always @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            ms_cnt_ff <= 32'h0000_0000;
            ms_tick_ff <= 1'b0;
        end else if (ms_cnt_ff >= MS_MAX) begin
            ms_cnt_ff <= 32'h0000_0000;
            ms_tick_ff <= 1'b1;
        end else begin
            ms_cnt_ff <= ms_cnt_ff + 32'h0000_0001;
            ms_tick_ff <= 1'b0;
        end
    end

    always @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            blink_cnt_ff <= 10'h000;
            flash_ff <= 1'b1;
        end else if (ms_tick_ff) begin
            if (blink_cnt_ff >= `AMR_BLINK_HALF_MS - 1) begin
                blink_cnt_ff <= 10'h000;
                flash_ff <= ~flash_ff;
            end else begin
                blink_cnt_ff <= blink_cnt_ff + 10'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Communication watchdog
    reg rx_prev_ff;
    reg [15:0] wdog_cnt_ff;
    reg wdog_err_ff;
    wire rx_seen = comm_rx ^ rx_prev_ff;

    // Any line edge counts as traffic; error clears on the next one
    always @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            rx_prev_ff <= 1'b0;
            wdog_cnt_ff <= 16'h0000;
            wdog_err_ff <= 1'b0;
        end else begin
            rx_prev_ff <= comm_rx;
            if (!ctrl_ff[`AMR_CTRL_WDOG_EN] || rx_seen) begin
                wdog_cnt_ff <= 16'h0000;
                wdog_err_ff <= 1'b0;
            end else if (ms_tick_ff) begin
                if (wdog_cnt_ff >= wdog_tmo_ff) begin
                    wdog_err_ff <= 1'b1;
                end else begin
                    wdog_cnt_ff <= wdog_cnt_ff + 16'h0001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Alarm aggregation
    reg [11:0] alarms;
    always @* begin
        alarms = 12'h000;
        alarms[`AMR_A_AUX_HIGH] = aux_high;
        alarms[`AMR_A_LINE_LOSS] = ~line_present & elec_powered;
        alarms[`AMR_A_AUX_LOW] = aux_low;
        alarms[`AMR_A_BAKEOUT] = bakeout;
        alarms[`AMR_A_HEATER] = res_high;
        alarms[`AMR_A_ILIMIT] = curr_over;
        alarms[`AMR_A_PHASE] = phase_loss;
        alarms[`AMR_A_CARD] = card_present & card_fail;
        alarms[`AMR_A_SHORT] = sw_stuck & out_cont_on;
        alarms[`AMR_A_OVERTEMP] = overtemp;
        alarms[`AMR_A_UNBAL] = |legs;
        alarms[`AMR_A_WDOG] = wdog_err_ff;
    end

    // Bakeout is a status message, not a fault, so it skips lamp and relay
    wire [11:0] fault_mask = ~(12'h001 << `AMR_A_BAKEOUT);
    wire [11:0] faults = alarms & fault_mask;
    // Overtemperature always trips the relay whatever the selection
    wire [11:0] relay_mask = relay_sel_ff | (12'h001 << `AMR_A_OVERTEMP);
    wire relay_trip = |(faults & relay_mask);

    reg lamp_ff;
    reg relay_ff;
    reg [11:0] msg_ff;
    reg alt_ff;
    reg power_off_ff;
    reg reduce_ff;
    reg [2:0] legs_ff;
    reg [11:0] alarms_prev_ff;

    always @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            lamp_ff <= 1'b0;
            relay_ff <= 1'b0;
            msg_ff <= 12'h000;
            alt_ff <= 1'b0;
            power_off_ff <= 1'b1;
            reduce_ff <= 1'b0;
            legs_ff <= 3'h0;
            alarms_prev_ff <= 12'h000;
        end else begin
            lamp_ff <= |faults;
            relay_ff <= aux_powered & ~relay_trip;
            msg_ff <= alarms;
            alt_ff <= |alarms;
            power_off_ff <= overtemp | wdog_err_ff;
            reduce_ff <= curr_over & ctrl_ff[`AMR_CTRL_REDUCE];
            legs_ff <= legs;
            alarms_prev_ff <= alarms;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Data logging
    reg [9:0] sec_cnt_ff;
    reg [7:0] log_sec_ff;
    reg log_act_ff;
    reg log_smp_ff;
    wire log_on = ctrl_ff[`AMR_CTRL_LOG_SW] | ctrl_ff[`AMR_CTRL_LOG_MENU] |
                  (ctrl_ff[`AMR_CTRL_LOG_DIN] & log_din);
    wire sec_tick = ms_tick_ff && (sec_cnt_ff >= `AMR_S_MS - 1);

    always @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            sec_cnt_ff <= 10'h000;
            log_sec_ff <= 8'h00;
            log_act_ff <= 1'b0;
            log_smp_ff <= 1'b0;
        end else begin
            log_act_ff <= log_on;
            log_smp_ff <= 1'b0;
            if (!log_on) begin
                sec_cnt_ff <= 10'h000;
                log_sec_ff <= 8'h00;
            end else if (ms_tick_ff) begin
                sec_cnt_ff <= sec_tick ? 10'h000 : sec_cnt_ff + 10'h001;
                if (sec_tick) begin
                    // Interval register clamped to at least one second
                    if (log_sec_ff + 8'h01 >= log_int_ff) begin
                        log_sec_ff <= 8'h00;
                        log_smp_ff <= 1'b1;
                    end else begin
                        log_sec_ff <= log_sec_ff + 8'h01;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB slave, one wait state so read data leaves a flip-flop
    wire apb_access = PSEL_IN & PENABLE_IN & ~pready_ff;
    wire apb_done = PSEL_IN & PENABLE_IN & pready_ff;
    wire apb_wr = apb_done & PWRITE_IN & ~pslverr_ff;
    reg mapped;
    reg [31:0] rd_mux;

    always @* begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (PADDR_IN)
            `AMR_OFF_CTRL: rd_mux = {27'h0, ctrl_ff};
            `AMR_OFF_RELAY_SEL: rd_mux = {20'h0, relay_sel_ff};
            `AMR_OFF_WDOG_TMO: rd_mux = {16'h0, wdog_tmo_ff};
            `AMR_OFF_LOG_CFG: rd_mux = {16'h0, log_int_ff, 4'h0, log_ch_ff};
            `AMR_OFF_COND: rd_mux = {15'h0, log_act_ff, 1'b0, legs_ff, msg_ff};
            `AMR_OFF_INT_STAT: rd_mux = {20'h0, int_stat_ff};
            `AMR_OFF_INT_CLR: rd_mux = 32'h0000_0000;
            `AMR_OFF_INT_EN: rd_mux = {20'h0, int_en_ff};
            default: mapped = 1'b0;
        endcase
    end

    always @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= apb_access;
            pslverr_ff <= apb_access & ~mapped;
            if (apb_access && !PWRITE_IN) begin
                prdata_ff <= rd_mux;
            end
        end
    end

    always @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            ctrl_ff <= `AMR_RST_CTRL;
            relay_sel_ff <= `AMR_RST_RELAY_SEL;
            wdog_tmo_ff <= `AMR_RST_WDOG_TMO;
            log_ch_ff <= `AMR_RST_LOG_CH;
            log_int_ff <= `AMR_RST_LOG_INT;
            int_en_ff <= 12'h000;
        end else if (apb_wr) begin
            case (PADDR_IN)
                `AMR_OFF_CTRL: ctrl_ff <= PWDATA_IN[4:0];
                `AMR_OFF_RELAY_SEL: relay_sel_ff <= PWDATA_IN[11:0];
                `AMR_OFF_WDOG_TMO: wdog_tmo_ff <= PWDATA_IN[15:0];
                `AMR_OFF_LOG_CFG: begin
                    log_ch_ff <= (PWDATA_IN[3:0] > `AMR_LOG_MAX_CH) ?
                                 `AMR_LOG_MAX_CH : PWDATA_IN[3:0];
                    log_int_ff <= (PWDATA_IN[15:8] < `AMR_LOG_MIN_S) ?
                                  `AMR_LOG_MIN_S : PWDATA_IN[15:8];
                end
                `AMR_OFF_INT_EN: int_en_ff <= PWDATA_IN[11:0];
                default: ctrl_ff <= ctrl_ff;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupts: rising alarm sets sticky bit; set beats clear
    wire [11:0] rise = alarms & ~alarms_prev_ff;
    wire clr_wr = apb_wr && (PADDR_IN == `AMR_OFF_INT_CLR);
    wire [11:0] clr_bits = clr_wr ? PWDATA_IN[11:0] : 12'h000;
    reg irq_ff;

    always @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            int_stat_ff <= 12'h000;
            irq_ff <= 1'b0;
        end else begin
            int_stat_ff <= (int_stat_ff & ~clr_bits) | rise;
            irq_ff <= |(((int_stat_ff & ~clr_bits) | rise) & int_en_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign PRDATA_OUT = prdata_ff;
    assign PREADY_OUT = pready_ff;
    assign PSLVERR_OUT = pslverr_ff;
    assign ALARM_LAMP_OUT = lamp_ff;
    assign RELAY_ENERGIZE_OUT = relay_ff;
    assign DISPLAY_MSG_OUT = msg_ff;
    assign DISPLAY_ALT_OUT = alt_ff;
    assign DISPLAY_FLASH_OUT = flash_ff;
    assign LOAD_POWER_OFF_OUT = power_off_ff;
    assign OUTPUT_REDUCE_OUT = reduce_ff;
    assign UNBAL_LEG_OUT = legs_ff;
    assign LOG_ACTIVE_OUT = log_act_ff;
    assign LOG_SAMPLE_OUT = log_smp_ff;
    assign LOG_CHANNELS_OUT = log_ch_ff;
    assign IRQ_OUT = irq_ff;

endmodule // amr_alarm_monitor_relay

// *** tb/amr_checker_assertions.sv ***
`timescale 1ns/10ps
module amr_checker #(
    parameter MS_CYCLES = 200000
) (
    input wire CLK_IN, // clock
    input wire RESET_N_IN, // sync reset
    input wire AUX_POWERED_IN, // aux feed
    input wire OVERTEMP_IN, // switch hot
    input wire [2:0] LEG_OUT_TOL_IN, // legs
    input wire ALARM_LAMP_OUT, // lamp
    input wire RELAY_ENERGIZE_OUT, // relay coil
    input wire [11:0] DISPLAY_MSG_OUT, // messages
    input wire DISPLAY_ALT_OUT, // message mode
    input wire LOAD_POWER_OFF_OUT, // load off
    input wire OUTPUT_REDUCE_OUT, // reduce
    input wire [2:0] UNBAL_LEG_OUT, // legs out
    input wire LOG_ACTIVE_OUT, // logging
    input wire LOG_SAMPLE_OUT // log strobe
);
    reg [1:0] warm_ff;
    wire warm = (warm_ff == 2'h3);
    // Pin history is meaningless until three edges after reset
    always @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            warm_ff <= 2'h0;
        end else if (!warm) begin
            warm_ff <= warm_ff + 2'h1;
        end
    end
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    ////////////////////////////////////////////////////////////
    property p_lamp_any;
        ALARM_LAMP_OUT == |(DISPLAY_MSG_OUT & 12'hFF7);
    endproperty
    a_lamp_any: assert property (p_lamp_any) else $error("lamp vs faults");
    property p_ot_trip;
        DISPLAY_MSG_OUT[9] |-> !RELAY_ENERGIZE_OUT && LOAD_POWER_OFF_OUT;
    endproperty
    a_ot_trip: assert property (p_ot_trip) else $error("overtemp not tripped");
    property p_relay_aux;
        warm && RELAY_ENERGIZE_OUT |-> $past(AUX_POWERED_IN, 3);
    endproperty
    a_relay_aux: assert property (p_relay_aux) else $error("relay without aux");
    property p_msg_alt;
        DISPLAY_ALT_OUT == |DISPLAY_MSG_OUT;
    endproperty
    a_msg_alt: assert property (p_msg_alt) else $error("display mode wrong");
    property p_wdog_off;
        DISPLAY_MSG_OUT[11] |-> LOAD_POWER_OFF_OUT;
    endproperty
    a_wdog_off: assert property (p_wdog_off) else $error("watchdog load on");
    property p_ot_sync;
        warm |-> DISPLAY_MSG_OUT[9] == $past(OVERTEMP_IN, 3);
    endproperty
    a_ot_sync: assert property (p_ot_sync) else $error("overtemp latency");
    property p_legs;
        warm |-> UNBAL_LEG_OUT == $past(LEG_OUT_TOL_IN, 3) && DISPLAY_MSG_OUT[10] == |UNBAL_LEG_OUT;
    endproperty
    a_legs: assert property (p_legs) else $error("leg report wrong");
    property p_reduce;
        OUTPUT_REDUCE_OUT |-> DISPLAY_MSG_OUT[5];
    endproperty
    a_reduce: assert property (p_reduce) else $error("reduce without flag");
    property p_log_pulse;
        LOG_SAMPLE_OUT |-> LOG_ACTIVE_OUT ##1 !LOG_SAMPLE_OUT [*8];
    endproperty
    a_log_pulse: assert property (p_log_pulse) else $error("log strobe wrong");
endmodule // amr_checker

// *** tb/amr_far_side.sv ***
`timescale 1ns/10ps
module amr_far_side (
    input wire clk_in, // system clock
    input wire chatty_in, // host sends traffic
    output reg rx_out = 1'b0 // receive activity line
);
    reg [3:0] gap_ff = 4'h0;
    // Host talks every ten cycles; going quiet starves the watchdog
    always @(posedge clk_in) begin
        if (chatty_in) begin
            gap_ff <= (gap_ff == 4'h9) ? 4'h0 : gap_ff + 4'h1;
            if (gap_ff == 4'h9) begin
                rx_out <= ~rx_out;
            end
        end
    end
endmodule // amr_far_side

// *** tb/tb_alarm_monitor_relay.sv ***
`timescale 1ns/10ps
`include "amr_defines.vh"
module tb_alarm_monitor_relay;
    localparam MSC = 8;
    localparam logic [31:0] RST_TAB [0:8] = '{32'h0, 32'hFFF, 32'h3E8, 32'h10A,
        32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    localparam [19:0] LCTL = 20'h08842;
    localparam [4:0] LDIN = 5'b10100;
    localparam [4:0] LEXP = 5'b00111;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg psel = 1'b0;
    reg pen = 1'b0;
    reg pwr = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg [17:0] cnd = 18'h0001C;
    reg chatty = 1'b0;
    wire rx, pready, pslverr, lamp, relay, alt, flash, loff, red, lact, lsmp, irq;
    wire [31:0] prdata;
    wire [11:0] msg;
    wire [2:0] ub;
    wire [3:0] lch;
    integer error_cnt = 0;
    integer samples_checked = 0;
    integer seed = 32'h765841A6;
    integer i, k;
    reg [31:0] rd;
    reg err;
    reg [11:0] sel = 12'hFFF;
    reg [4:0] ctl = 5'h00;
    reg [11:0] m;
    reg fl;
    initial forever #2.5 clk = ~clk;
    amr_alarm_monitor_relay #(.MS_CYCLES(MSC)) dut_u (
        .CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .AUX_HIGH_IN(cnd[0]),
        .AUX_LOW_IN(cnd[1]), .LINE_PRESENT_IN(cnd[2]), .ELEC_POWERED_IN(cnd[3]),
        .AUX_POWERED_IN(cnd[4]), .BAKEOUT_ACTIVE_IN(cnd[5]), .LOAD_RES_HIGH_IN(cnd[6]),
        .CURRENT_OVER_IN(cnd[7]), .PHASE_LOSS_IN(cnd[8]), .CARD_PRESENT_IN(cnd[9]),
        .CARD_FAIL_IN(cnd[10]), .SWITCH_STUCK_IN(cnd[11]), .OUTPUT_CONT_ON_IN(cnd[12]),
        .OVERTEMP_IN(cnd[13]), .LEG_OUT_TOL_IN(cnd[16:14]), .COMM_RX_IN(rx),
        .LOG_DIN_IN(cnd[17]), .ALARM_LAMP_OUT(lamp), .RELAY_ENERGIZE_OUT(relay),
        .DISPLAY_MSG_OUT(msg), .DISPLAY_ALT_OUT(alt), .DISPLAY_FLASH_OUT(flash),
        .LOAD_POWER_OFF_OUT(loff), .OUTPUT_REDUCE_OUT(red), .UNBAL_LEG_OUT(ub),
        .LOG_ACTIVE_OUT(lact), .LOG_SAMPLE_OUT(lsmp), .LOG_CHANNELS_OUT(lch),
        .IRQ_OUT(irq));
    amr_far_side far_u (.clk_in(clk), .chatty_in(chatty), .rx_out(rx));
    ////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task conclude;
        begin
            $display("checks %0d errors %0d", samples_checked, error_cnt);
            if (error_cnt == 0 && samples_checked > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // A wait that used up its bound ends the run as a failure
    task expire(input integer n, input integer lim);
        begin
            if (n >= lim) begin
                error_cnt = error_cnt + 1;
                conclude;
            end
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        integer n;
        begin
            psel <= 1'b1;
            pwr <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            pen <= 1'b1;
            n = 0;
            @(posedge clk);
            while (pready !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge clk);
            end
            if (pready !== 1'b1) begin
                error_cnt = error_cnt + 1;
                conclude;
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            pen <= 1'b0;
            @(posedge clk);
        end
    endtask
    // Two sync stages plus the output register
    task settle;
        repeat (4) @(posedge clk);
    endtask
    // Reference model of the alarm vector, written from the rules
    function [11:0] exp_msg(input [17:0] c, input wd);
        exp_msg = {wd, |c[16:14], c[13], c[11] & c[12], c[9] & c[10], c[8], c[7], c[6],
            c[5], c[1], ~c[2] & c[3], c[0]};
    endfunction
    task cmp(input wd);
        begin
            m = exp_msg(cnd, wd);
            chk("msg", 32'(msg), 32'(m));
            chk("lamp", 32'(lamp), 32'(|(m & 12'hFF7)));
            chk("relay", 32'(relay), 32'(cnd[4] & ~|(m & (sel | 12'h200) & 12'hFF7)));
            chk("loadoff", 32'(loff), 32'(m[9] | m[11]));
            chk("reduce", 32'(red), 32'(cnd[7] & ctl[4]));
            chk("legs", 32'(ub), 32'(cnd[16:14]));
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        settle;
        cmp(1'b0);
        for (k = 0; k < 9; k = k + 1) begin
            apb(1'b0, 8'(4 * k), 32'h0);
            chk("rstval", rd, RST_TAB[k]);
            chk("slverr", 32'(err), 32'(k == 8));
        end
        for (i = 0; i < 60; i = i + 1) begin
            if (i % 6 == 0) begin
                sel = 12'($random(seed));
                ctl = 5'($random(seed)) & 5'h10;
                apb(1'b1, `AMR_OFF_RELAY_SEL, 32'(sel));
                apb(1'b1, `AMR_OFF_CTRL, 32'(ctl));
                apb(1'b1, `AMR_OFF_COND, 32'hFFFF);
                apb(1'b0, `AMR_OFF_RELAY_SEL, 32'h0);
                chk("sel", rd, 32'(sel));
            end
            cnd <= 18'($random(seed) & $random(seed) & $random(seed)) ^ 18'h0001C;
            settle;
            cmp(1'b0);
            apb(1'b0, `AMR_OFF_COND, 32'h0);
            chk("cond", rd, {17'h0, cnd[16:14], m});
        end
        cnd <= 18'h0001C;
        settle;
        apb(1'b1, `AMR_OFF_INT_CLR, 32'hFFF);
        apb(1'b1, `AMR_OFF_INT_EN, 32'h200);
        chk("irq", 32'(irq), 32'h0);
        cnd <= 18'h0201D;
        settle;
        settle;
        chk("irq", 32'(irq), 32'h1);
        apb(1'b0, `AMR_OFF_INT_STAT, 32'h0);
        chk("stat", rd, 32'h201);
        apb(1'b1, `AMR_OFF_INT_CLR, 32'h200);
        chk("irq", 32'(irq), 32'h0);
        apb(1'b0, `AMR_OFF_INT_STAT, 32'h0);
        chk("stat", rd, 32'h001);
        cnd <= 18'h0001C;
        apb(1'b1, `AMR_OFF_WDOG_TMO, 32'h3);
        chatty <= 1'b1;
        apb(1'b1, `AMR_OFF_CTRL, 32'h1);
        repeat (100) @(posedge clk);
        cmp(1'b0);
        chatty <= 1'b0;
        for (k = 0; k < 200 && msg[11] !== 1'b1; k = k + 1) @(posedge clk);
        expire(k, 200);
        settle;
        cmp(1'b1);
        chatty <= 1'b1;
        for (k = 0; k < 60 && msg[11] !== 1'b0; k = k + 1) @(posedge clk);
        expire(k, 60);
        settle;
        cmp(1'b0);
        apb(1'b1, `AMR_OFF_LOG_CFG, 32'hF);
        apb(1'b0, `AMR_OFF_LOG_CFG, 32'h0);
        chk("logcfg", rd, 32'h10A);
        chk("logch", 32'(lch), 32'hA);
        for (k = 0; k < 5; k = k + 1) begin
            cnd <= {LDIN[k], 17'h0001C};
            apb(1'b1, `AMR_OFF_CTRL, 32'(LCTL[4 * k +: 4]));
            settle;
            chk("logact", 32'(lact), 32'(LEXP[k]));
        end
        apb(1'b1, `AMR_OFF_CTRL, 32'h2);
        for (k = 0; k < 9000 && lsmp !== 1'b1; k = k + 1) @(posedge clk);
        expire(k, 9000);
        // Tick phase at enable is free, so allow a few cycles either way
        chk("interval", 32'(k >= 7990 && k <= 8010), 32'h1);
        @(posedge clk);
        chk("strobe", 32'(lsmp), 32'h0);
        // Flash phase: measure one full half period between two toggles
        fl = flash;
        for (k = 0; k < 4100 && flash === fl; k = k + 1) @(posedge clk);
        expire(k, 4100);
        fl = flash;
        for (k = 0; k < 4100 && flash === fl; k = k + 1) @(posedge clk);
        chk("flash", 32'(k), 32'(`AMR_BLINK_HALF_MS * MSC));
        conclude;
    end
endmodule // tb_alarm_monitor_relay
bind amr_alarm_monitor_relay amr_checker #(.MS_CYCLES(MS_CYCLES)) chk_u (
    .CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .AUX_POWERED_IN(AUX_POWERED_IN),
    .OVERTEMP_IN(OVERTEMP_IN), .LEG_OUT_TOL_IN(LEG_OUT_TOL_IN),
    .ALARM_LAMP_OUT(ALARM_LAMP_OUT), .RELAY_ENERGIZE_OUT(RELAY_ENERGIZE_OUT),
    .DISPLAY_MSG_OUT(DISPLAY_MSG_OUT), .DISPLAY_ALT_OUT(DISPLAY_ALT_OUT),
    .LOAD_POWER_OFF_OUT(LOAD_POWER_OFF_OUT), .OUTPUT_REDUCE_OUT(OUTPUT_REDUCE_OUT),
    .UNBAL_LEG_OUT(UNBAL_LEG_OUT), .LOG_ACTIVE_OUT(LOG_ACTIVE_OUT),
    .LOG_SAMPLE_OUT(LOG_SAMPLE_OUT));
